// File: hdl/ndq_params.svh
`ifndef NDQ_PARAMS_SVH
`define NDQ_PARAMS_SVH

// Register byte offsets.
`define NDQ_OFF_CTRL      8'h00
`define NDQ_OFF_PRIO      8'h04
`define NDQ_OFF_TUNE0     8'h08
`define NDQ_OFF_TUNE1     8'h0C
`define NDQ_OFF_DADDR     8'h10
`define NDQ_OFF_DLENCMD   8'h14
`define NDQ_OFF_TXCOMMIT  8'h18
`define NDQ_OFF_TXSTAT    8'h1C
`define NDQ_OFF_RXPOST    8'h20
`define NDQ_OFF_RXSTAT    8'h24
`define NDQ_OFF_CAPS      8'h28

// Control register bit positions.
`define NDQ_CTRL_TX_EN    0
`define NDQ_CTRL_RX_EN    1
`define NDQ_CTRL_MULTI    2
`define NDQ_CTRL_Q1_EN    3
`define NDQ_CTRL_VMQ_EN   4
`define NDQ_CTRL_RSS_EN   5
`define NDQ_CTRL_TSYNC_EN 6
`define NDQ_CTRL_FLR      31
`define NDQ_CTRL_MASK     32'h0000007F

// Descriptor command bit positions inside the command byte.
`define NDQ_CMD_EOP       0
`define NDQ_CMD_VLAN      1
`define NDQ_CMD_CSUM      2

// Reset values.
`define NDQ_CTRL_RST      32'h00000000
`define NDQ_TUNE_RST      8'h01
`define NDQ_ADDR_RST      32'h00000000
`define NDQ_LENCMD_RST    24'h000000

// Sizes and capability values.
`define NDQ_DESC_W        56
`define NDQ_MEM_DEPTH     8
`define NDQ_CREDIT_MAX    3'h7
`define NDQ_KEY_BITS      8'h80
`define NDQ_GCM_CAP       1'b1

`endif

// File: hdl/ndq_pkg.sv
package ndq_pkg;

  // Transmit engine states, Gray coded along the fetch path.
  typedef enum logic [1:0] {
    NDQ_TX_IDLE = 2'b00,
    NDQ_TX_READ = 2'b01,
    NDQ_TX_PUSH = 2'b11,
    NDQ_TX_WB   = 2'b10
  } ndq_tx_state_t;

  // Ring pointer with one wrap bit above a two-bit slot index.
  typedef logic [2:0] ndq_ptr_t;

endpackage

// File: hdl/ndq_mem.sv
`timescale 1ns/1ns
`include "ndq_params.svh"
module ndq_mem
  import ndq_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   wr_en,
  input  wire logic [2:0]             wr_addr,
  input  wire logic [`NDQ_DESC_W-1:0] wr_data,
  input  wire logic                   rd_en,
  input  wire logic [2:0]             rd_addr,
  output logic      [`NDQ_DESC_W-1:0] rd_data
);

  logic [`NDQ_DESC_W-1:0] mem [`NDQ_MEM_DEPTH];
  logic [`NDQ_DESC_W-1:0] next_rd_data;

  // Read data is held until the next read.
  always_comb begin
    next_rd_data = rd_en ? mem[rd_addr] : rd_data;
  end

  // Storage needs no reset; only the read register does.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

// File: hdl/ndq_buf2.sv
`timescale 1ns/1ns
module ndq_buf2
  import ndq_pkg::*;
#(
  parameter int WIDTH = 57
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic             valid0;
  logic             valid1;
  logic [WIDTH-1:0] ent1;
  logic             next_valid0;
  logic             next_valid1;
  logic [WIDTH-1:0] next_ent0;
  logic [WIDTH-1:0] next_ent1;
  logic             push;
  logic             pop;

  // Entry zero is the head; ready drops only when both entries hold data.
  assign in_ready  = !valid1;
  assign out_valid = valid0;

  always_comb begin
    push        = in_valid && !valid1;
    pop         = valid0 && out_ready;
    next_valid0 = valid0;
    next_valid1 = valid1;
    next_ent0   = out_data;
    next_ent1   = ent1;
    if (pop) begin
      if (valid1) begin
        next_ent0   = ent1;
        next_ent1   = in_data;
        next_valid1 = push;
      end else begin
        next_ent0   = in_data;
        next_valid0 = push;
      end
    end else if (push) begin
      if (!valid0) begin
        next_ent0   = in_data;
        next_valid0 = 1'b1;
      end else begin
        next_ent1   = in_data;
        next_valid1 = 1'b1;
      end
    end
    if (clear) begin
      next_valid0 = 1'b0;
      next_valid1 = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid0   <= 1'b0;
      valid1   <= 1'b0;
      out_data <= '0;
      ent1     <= '0;
    end else begin
      valid0   <= next_valid0;
      valid1   <= next_valid1;
      out_data <= next_ent0;
      ent1     <= next_ent1;
    end
  end

endmodule

// File: hdl/ndq_top.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "ndq_params.svh"
// Function
// - A receive buffer stays with hardware until a good packet lands in it, then returns.
// - A transmit buffer is hardware owned from commit until it is loaded toward the FIFO.
// - Each descriptor holds buffer address, buffer length and status or command bits.
// - Each descriptor has an end-of-packet bit marking the last buffer of a packet.
// - Transmit descriptors carry per-packet type and offload requests such as VLAN or checksum.
// - Two independent transmit rings share the same fetch and completion logic.
// - Software chooses the preferred transmit queue through a register.
// - Two tuning registers set how many descriptors each queue sends per turn.
// - A software function-level reset clears the control, ring and credit state like a bus reset, but not the duplex synchronizer or write-back data.
// - With VM queuing on, a one-bit index per packet selects its receive queue.
// - Two receive queues exist and each packet goes into exactly one of them.
// - Time sync can be active only in full duplex, at any link speed.
// - The link security capability reports AES-GCM with a 128-bit key.
module ndq_top
  import ndq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        full_duplex_pin,
  input  wire logic        rx_pkt_valid,
  input  wire logic        rx_pkt_good,
  input  wire logic [15:0] rx_pkt_len,
  input  wire logic        rx_vm_index,
  input  wire logic        rx_hash_queue,
  output logic             rx_wb_valid,
  output logic             rx_wb_queue,
  output logic      [15:0] rx_wb_len,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [31:0] tx_buf_addr,
  output logic      [15:0] tx_buf_len,
  output logic      [7:0]  tx_cmd,
  output logic             tx_eop,
  output logic             tx_queue,
  output logic             tx_wb_valid,
  output logic             tx_wb_queue,
  output logic      [1:0]  tx_wb_index,
  output logic             tsync_active
);

  // Ring helpers shared by both transmit queues.
  function automatic logic ring_empty(input ndq_ptr_t h, input ndq_ptr_t t);
    ring_empty = (h == t);
  endfunction

  function automatic logic ring_full(input ndq_ptr_t h, input ndq_ptr_t t);
    ring_full = (h[2] != t[2]) && (h[1:0] == t[1:0]);
  endfunction

  function automatic logic [7:0] burst_limit(input logic [7:0] tune);
    burst_limit = (tune == 8'h00) ? 8'h01 : tune;
  endfunction

  logic [31:0]          ctrl, next_ctrl;
  logic                 prio, next_prio;
  logic [7:0]           tune0, next_tune0;
  logic [7:0]           tune1, next_tune1;
  logic [31:0]          stage_addr, next_stage_addr;
  logic [23:0]          stage_lencmd, next_stage_lencmd;
  logic [31:0]          next_rdata;
  logic                 function_level_reset, next_flr;
  logic                 fd_meta, fd_sync;
  logic                 next_tsync;
  logic                 commit_req;
  logic                 post_req;
  ndq_tx_state_t        state, next_state;
  ndq_ptr_t             head0, next_head0, tail0, next_tail0;
  ndq_ptr_t             head1, next_head1, tail1, next_tail1;
  logic                 sel, next_sel;
  logic                 cur, next_cur;
  logic [7:0]           burst, next_burst;
  logic                 next_tx_wb_valid, next_tx_wb_queue;
  logic [1:0]           next_tx_wb_index;
  logic [2:0]           credit0, next_credit0;
  logic [2:0]           credit1, next_credit1;
  logic [7:0]           drops, next_drops;
  logic                 next_rx_wb_valid, next_rx_wb_queue;
  logic [15:0]          next_rx_wb_len;
  logic                 have0, have1, have_cur, have_oth, rx_q, commit_ok;
  logic [7:0]           lim;
  logic                 mem_wr, mem_rd;
  logic [2:0]           mem_wr_addr, mem_rd_addr;
  logic [`NDQ_DESC_W-1:0] mem_rd_data;
  logic                 buf_in_valid, buf_in_ready;
  logic [`NDQ_DESC_W:0] buf_out;

  // Register decode, read data and time sync gating.
  always_comb begin
    next_ctrl         = ctrl;
    next_prio         = prio;
    next_tune0        = tune0;
    next_tune1        = tune1;
    next_stage_addr   = stage_addr;
    next_stage_lencmd = stage_lencmd;
    next_rdata        = 32'h00000000;
    next_flr          = 1'b0;
    commit_req        = 1'b0;
    post_req          = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `NDQ_OFF_CTRL) begin
        next_ctrl = reg_wdata & `NDQ_CTRL_MASK;
        next_flr  = reg_wdata[`NDQ_CTRL_FLR];
      end else if (reg_addr == `NDQ_OFF_PRIO) begin
        next_prio = reg_wdata[0];
      end else if (reg_addr == `NDQ_OFF_TUNE0) begin
        next_tune0 = reg_wdata[7:0];
      end else if (reg_addr == `NDQ_OFF_TUNE1) begin
        next_tune1 = reg_wdata[7:0];
      end else if (reg_addr == `NDQ_OFF_DADDR) begin
        next_stage_addr = reg_wdata;
      end else if (reg_addr == `NDQ_OFF_DLENCMD) begin
        next_stage_lencmd = reg_wdata[23:0];
      end else if (reg_addr == `NDQ_OFF_TXCOMMIT) begin
        commit_req = 1'b1;
      end else if (reg_addr == `NDQ_OFF_RXPOST) begin
        post_req = 1'b1;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `NDQ_OFF_CTRL) begin
        next_rdata = ctrl;
      end else if (reg_addr == `NDQ_OFF_PRIO) begin
        next_rdata = {31'h00000000, prio};
      end else if (reg_addr == `NDQ_OFF_TUNE0) begin
        next_rdata = {24'h000000, tune0};
      end else if (reg_addr == `NDQ_OFF_TUNE1) begin
        next_rdata = {24'h000000, tune1};
      end else if (reg_addr == `NDQ_OFF_DADDR) begin
        next_rdata = stage_addr;
      end else if (reg_addr == `NDQ_OFF_DLENCMD) begin
        next_rdata = {8'h00, stage_lencmd};
      end else if (reg_addr == `NDQ_OFF_TXSTAT) begin
        next_rdata = {16'h0000, 1'b0, tail1, 1'b0, head1, 1'b0, tail0, 1'b0, head0};
      end else if (reg_addr == `NDQ_OFF_RXSTAT) begin
        next_rdata = {14'h0000, fd_sync, tsync_active, drops, 1'b0, credit1, 1'b0, credit0};
      end else if (reg_addr == `NDQ_OFF_CAPS) begin
        next_rdata = {23'h000000, `NDQ_GCM_CAP, `NDQ_KEY_BITS};
      end
    end
    next_tsync = ctrl[`NDQ_CTRL_TSYNC_EN] && fd_sync;
    if (function_level_reset) begin
      next_ctrl         = `NDQ_CTRL_RST;
      next_prio         = 1'b0;
      next_tune0        = `NDQ_TUNE_RST;
      next_tune1        = `NDQ_TUNE_RST;
      next_stage_addr   = `NDQ_ADDR_RST;
      next_stage_lencmd = `NDQ_LENCMD_RST;
      next_tsync        = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl         <= `NDQ_CTRL_RST;
      prio         <= 1'b0;
      tune0        <= `NDQ_TUNE_RST;
      tune1        <= `NDQ_TUNE_RST;
      stage_addr   <= `NDQ_ADDR_RST;
      stage_lencmd <= `NDQ_LENCMD_RST;
      reg_rdata    <= 32'h00000000;
      function_level_reset          <= 1'b0;
      fd_meta      <= 1'b0;
      fd_sync      <= 1'b0;
      tsync_active <= 1'b0;
    end else begin
      ctrl         <= next_ctrl;
      prio         <= next_prio;
      tune0        <= next_tune0;
      tune1        <= next_tune1;
      stage_addr   <= next_stage_addr;
      stage_lencmd <= next_stage_lencmd;
      reg_rdata    <= next_rdata;
      function_level_reset          <= next_flr;
      fd_meta      <= full_duplex_pin;
      fd_sync      <= fd_meta;
      tsync_active <= next_tsync;
    end
  end

  // Transmit rings, arbitration, fetch and write-back.
  always_comb begin
    next_state       = state;
    next_head0       = head0;
    next_tail0       = tail0;
    next_head1       = head1;
    next_tail1       = tail1;
    next_sel         = sel;
    next_cur         = cur;
    next_burst       = burst;
    next_tx_wb_valid = 1'b0;
    next_tx_wb_queue = tx_wb_queue;
    next_tx_wb_index = tx_wb_index;
    have1     = ctrl[`NDQ_CTRL_TX_EN] && ctrl[`NDQ_CTRL_Q1_EN] && ctrl[`NDQ_CTRL_MULTI]
                && !ring_empty(head1, tail1);
    have0     = ctrl[`NDQ_CTRL_TX_EN] && !ring_empty(head0, tail0);
    have_cur  = cur ? have1 : have0;
    have_oth  = cur ? have0 : have1;
    lim       = burst_limit(cur ? tune1 : tune0);
    commit_ok = commit_req && (reg_wdata[0] ? !ring_full(head1, tail1)
                                            : !ring_full(head0, tail0));
    if (commit_ok) begin
      if (reg_wdata[0]) begin
        next_tail1 = tail1 + 3'h1;
      end else begin
        next_tail0 = tail0 + 3'h1;
      end
    end
    case (state)
      NDQ_TX_IDLE: begin
        if (have_cur && ((burst < lim) || !have_oth)) begin
          next_sel   = cur;
          next_burst = (burst < lim) ? 8'(burst + 8'h01) : 8'h01;
          next_state = NDQ_TX_READ;
        end else if (have_oth) begin
          next_sel   = !cur;
          next_cur   = !cur;
          next_burst = 8'h01;
          next_state = NDQ_TX_READ;
        end else begin
          next_cur   = prio;
          next_burst = 8'h00;
        end
      end
      NDQ_TX_READ: begin
        next_state = NDQ_TX_PUSH;
      end
      NDQ_TX_PUSH: begin
        if (buf_in_ready) begin
          next_state       = NDQ_TX_WB;
          next_tx_wb_valid = 1'b1;
          next_tx_wb_queue = sel;
          next_tx_wb_index = sel ? head1[1:0] : head0[1:0];
        end
      end
      NDQ_TX_WB: begin
        if (sel) begin
          next_head1 = head1 + 3'h1;
        end else begin
          next_head0 = head0 + 3'h1;
        end
        next_state = NDQ_TX_IDLE;
      end
      default: begin
        next_state = NDQ_TX_IDLE;
      end
    endcase
    if (function_level_reset) begin
      next_state       = NDQ_TX_IDLE;
      next_head0       = 3'h0;
      next_tail0       = 3'h0;
      next_head1       = 3'h0;
      next_tail1       = 3'h0;
      next_sel         = 1'b0;
      next_cur         = 1'b0;
      next_burst       = 8'h00;
      next_tx_wb_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= NDQ_TX_IDLE;
      head0       <= 3'h0;
      tail0       <= 3'h0;
      head1       <= 3'h0;
      tail1       <= 3'h0;
      sel         <= 1'b0;
      cur         <= 1'b0;
      burst       <= 8'h00;
      tx_wb_valid <= 1'b0;
      tx_wb_queue <= 1'b0;
      tx_wb_index <= 2'h0;
    end else begin
      state       <= next_state;
      head0       <= next_head0;
      tail0       <= next_tail0;
      head1       <= next_head1;
      tail1       <= next_tail1;
      sel         <= next_sel;
      cur         <= next_cur;
      burst       <= next_burst;
      tx_wb_valid <= next_tx_wb_valid;
      tx_wb_queue <= next_tx_wb_queue;
      tx_wb_index <= next_tx_wb_index;
    end
  end

  // Descriptor storage: queue bit above the slot index.
  assign mem_wr       = commit_ok;
  assign mem_wr_addr  = {reg_wdata[0], reg_wdata[0] ? tail1[1:0] : tail0[1:0]};
  assign mem_rd       = (state == NDQ_TX_READ);
  assign mem_rd_addr  = {sel, sel ? head1[1:0] : head0[1:0]};
  assign buf_in_valid = (state == NDQ_TX_PUSH);

  ndq_mem u_mem (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (mem_wr),
    .wr_addr (mem_wr_addr),
    .wr_data ({stage_addr, stage_lencmd}),
    .rd_en   (mem_rd),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

  // Two-entry buffer toward the transmit FIFO absorbs receiver stalls.
  ndq_buf2 #(.WIDTH(`NDQ_DESC_W + 1)) u_buf (
    .clk       (clk),
    .rst       (rst),
    .clear     (function_level_reset),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({sel, mem_rd_data}),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out)
  );

  assign tx_eop      = buf_out[16 + `NDQ_CMD_EOP];
  assign tx_queue    = buf_out[`NDQ_DESC_W];
  assign tx_buf_addr = buf_out[55:24];
  assign tx_buf_len  = buf_out[15:0];
  assign tx_cmd      = buf_out[23:16];

  // Receive steering, buffer credits and write-back.
  always_comb begin
    next_credit0     = credit0;
    next_credit1     = credit1;
    next_drops       = drops;
    next_rx_wb_valid = 1'b0;
    next_rx_wb_queue = rx_wb_queue;
    next_rx_wb_len   = rx_wb_len;
    // VM queuing wins if both set
    rx_q = ctrl[`NDQ_CTRL_VMQ_EN] ? rx_vm_index
         : (ctrl[`NDQ_CTRL_RSS_EN] ? rx_hash_queue : 1'b0);
    if (rx_pkt_valid && ctrl[`NDQ_CTRL_RX_EN]) begin
      if (rx_pkt_good && ((rx_q ? credit1 : credit0) != 3'h0)) begin
        next_rx_wb_valid = 1'b1;
        next_rx_wb_queue = rx_q;
        next_rx_wb_len   = rx_pkt_len;
        if (rx_q) begin
          next_credit1 = credit1 - 3'h1;
        end else begin
          next_credit0 = credit0 - 3'h1;
        end
      end else begin
        next_drops = drops + 8'h01;
      end
    end
    if (post_req) begin
      if (reg_wdata[0] && (next_credit1 != `NDQ_CREDIT_MAX)) begin
        next_credit1 = next_credit1 + 3'h1;
      end else if (!reg_wdata[0] && (next_credit0 != `NDQ_CREDIT_MAX)) begin
        next_credit0 = next_credit0 + 3'h1;
      end
    end
    if (function_level_reset) begin
      next_credit0     = 3'h0;
      next_credit1     = 3'h0;
      next_drops       = 8'h00;
      next_rx_wb_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      credit0     <= 3'h0;
      credit1     <= 3'h0;
      drops       <= 8'h00;
      rx_wb_valid <= 1'b0;
      rx_wb_queue <= 1'b0;
      rx_wb_len   <= 16'h0000;
    end else begin
      credit0     <= next_credit0;
      credit1     <= next_credit1;
      drops       <= next_drops;
      rx_wb_valid <= next_rx_wb_valid;
      rx_wb_queue <= next_rx_wb_queue;
      rx_wb_len   <= next_rx_wb_len;
    end
  end

endmodule

// File: sim/ndq_top_chk.sv
`timescale 1ns/1ns
`include "ndq_params.svh"
// Port-level timing checks for the descriptor queue block.
module ndq_top_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        full_duplex_pin,
  input wire logic        rx_pkt_valid,
  input wire logic        rx_pkt_good,
  input wire logic        rx_vm_index,
  input wire logic        rx_hash_queue,
  input wire logic        rx_wb_valid,
  input wire logic        rx_wb_queue,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [31:0] tx_buf_addr,
  input wire logic [7:0]  tx_cmd,
  input wire logic        tx_eop,
  input wire logic        tx_queue,
  input wire logic        tx_wb_valid,
  input wire logic        tx_wb_queue,
  input wire logic        tsync_active
);
  logic [6:0] sh;
  logic [6:0] next_sh;
  logic       exp_q;
  // Mirrors the control word; a function reset clears it.
  always_comb begin
    next_sh = sh;
    if (reg_wr && reg_addr == `NDQ_OFF_CTRL) begin
      next_sh = reg_wdata[`NDQ_CTRL_FLR] ? 7'h00 : reg_wdata[6:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh <= 7'h00;
    end else begin
      sh <= next_sh;
    end
  end
  // Queue a packet should reach under the current steering mode.
  assign exp_q = sh[4] ? rx_vm_index : (sh[5] & rx_hash_queue);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_buf_addr) && $stable(tx_cmd) && $stable(tx_queue))
    else $error("tx offer moved while stalled");
  AST_TX_EOP: assert property (tx_valid |-> tx_eop == tx_cmd[0])
    else $error("tx_eop differs from command");
  AST_RX_CAUSE: assert property (rx_wb_valid |->
    $past(rx_pkt_valid && rx_pkt_good && sh[1])) else $error("rx return without packet");
  AST_RX_BAD: assert property (rx_pkt_valid && !rx_pkt_good |=> !rx_wb_valid)
    else $error("bad packet returned");
  AST_RX_QUEUE: assert property (rx_wb_valid |-> rx_wb_queue == $past(exp_q))
    else $error("rx queue wrong");
  AST_TX_WB: assert property (tx_wb_valid |=> !tx_wb_valid)
    else $error("tx write-back too close");
  AST_TX_Q1: assert property (tx_wb_valid && tx_wb_queue |-> sh[2] && sh[3])
    else $error("queue one served while off");
  AST_TS_FD: assert property (!full_duplex_pin [*4] |=> !tsync_active)
    else $error("time sync in half duplex");
endmodule

bind ndq_top ndq_top_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .full_duplex_pin(full_duplex_pin),
  .rx_pkt_valid(rx_pkt_valid), .rx_pkt_good(rx_pkt_good), .rx_vm_index(rx_vm_index),
  .rx_hash_queue(rx_hash_queue), .rx_wb_valid(rx_wb_valid), .rx_wb_queue(rx_wb_queue),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_buf_addr(tx_buf_addr), .tx_cmd(tx_cmd),
  .tx_eop(tx_eop), .tx_queue(tx_queue), .tx_wb_valid(tx_wb_valid),
  .tx_wb_queue(tx_wb_queue), .tsync_active(tsync_active));

// File: sim/ndq_host_sink.sv
`timescale 1ns/1ns
// Far-side transmit sink that stalls about one cycle in four.
module ndq_host_sink (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tx_ready
);
  integer seed = 32'h7924B3DA;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ($random(seed) & 3) != 0;
    end
  end
endmodule

// File: sim/test_nic_descriptor_queue_control.sv
`timescale 1ns/1ns
`include "ndq_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
// Drives registers and packets and checks each result against its note.
module test_nic_descriptor_queue_control;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        fdx = 1'b1;
  logic        rx_pkt_valid = 1'b0;
  logic        rx_pkt_good = 1'b0;
  logic        rx_vm_index = 1'b0;
  logic        rx_hash_queue = 1'b0;
  logic [15:0] rx_pkt_len = 16'h0;
  logic        rd_pend = 1'b0;
  logic [31:0] reg_rdata, tx_buf_addr;
  logic [15:0] rx_wb_len, tx_buf_len;
  logic [7:0]  tx_cmd;
  logic        rx_wb_valid, rx_wb_queue, tx_valid, tx_ready, tx_eop, tx_queue;
  logic        tx_wb_valid, tx_wb_queue, tsync_active;
  logic [1:0]  tx_wb_index;
  integer      seed = 32'h7924B3DA;
  logic [56:0] ev;
  logic [56:0] tx_q[$];
  logic [55:0] cq0[$], cq1[$];
  logic [31:0] rd_q[$];
  logic [16:0] rx_q[$];
  logic [6:0]  ctl = 7'h00;
  logic [2:0]  cred[2] = '{3'h0, 3'h0};
  logic [7:0]  drops = 8'h00;
  bit          ord[6] = '{1, 0, 0, 1, 0, 0};
  int          nq[2] = '{0, 0};
  int          num_errors = 0;
  int          cmp_count = 0;
  int          wb_cnt = 0;
  int          ws[2] = '{0, 0};

  always #5 clk = ~clk;

  ndq_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .full_duplex_pin(fdx),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_good(rx_pkt_good), .rx_pkt_len(rx_pkt_len),
    .rx_vm_index(rx_vm_index), .rx_hash_queue(rx_hash_queue), .rx_wb_valid(rx_wb_valid),
    .rx_wb_queue(rx_wb_queue), .rx_wb_len(rx_wb_len), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_buf_addr(tx_buf_addr), .tx_buf_len(tx_buf_len),
    .tx_cmd(tx_cmd), .tx_eop(tx_eop), .tx_queue(tx_queue), .tx_wb_valid(tx_wb_valid),
    .tx_wb_queue(tx_wb_queue), .tx_wb_index(tx_wb_index), .tsync_active(tsync_active));
  ndq_host_sink host (.clk(clk), .rst(rst), .tx_ready(tx_ready));

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Stages one descriptor and commits it; a full ring keeps no note.
  task automatic commit(input logic q, input logic [2:0] c);
    logic [31:0] r;
    r = $random(seed);
    wr(`NDQ_OFF_DADDR, r);
    wr(`NDQ_OFF_DLENCMD, {13'h0, c, r[15:0]});
    wr(`NDQ_OFF_TXCOMMIT, {31'h0, q});
    if (nq[q] < 4) begin
      if (q) cq1.push_back({r, r[15:0], 5'h00, c});
      else cq0.push_back({r, r[15:0], 5'h00, c});
      nq[q]++;
    end
  endtask

  // Sends one packet and notes a return or a drop.
  task automatic pkt(input logic good);
    logic [31:0] r;
    logic        q;
    r = $random(seed);
    q = ctl[4] ? r[16] : (ctl[5] & r[17]);
    if (ctl[1] && good && cred[q] != 3'h0) begin
      cred[q]--;
      rx_q.push_back({q, r[15:0]});
    end else if (ctl[1]) begin
      drops++;
    end
    @(posedge clk);
    rx_pkt_valid  <= 1'b1;
    rx_pkt_good   <= good;
    rx_vm_index   <= r[16];
    rx_hash_queue <= r[17];
    rx_pkt_len    <= r[15:0];
    @(posedge clk);
    rx_pkt_valid <= 1'b0;
  endtask

  task automatic drain(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if (tx_q.size() + rx_q.size() + rd_q.size() == 0) break;
      @(posedge clk);
    end
    if (i == n) begin
      num_errors++;
      $display("MISMATCH pending notes exp 0 got %0d", tx_q.size() + rx_q.size());
      finish_test();
    end
  endtask

  // Takes the oldest note as each result appears and compares.
  always @(posedge clk) begin
    if (rd_pend) begin
      ev = 57'(rd_q.pop_front());
      `CHK("reg_rdata", ev, reg_rdata)
    end
    rd_pend <= reg_rd;
    if (tx_valid && tx_ready) begin
      ev = tx_q.pop_front();
      `CHK("tx_desc", ev, {tx_queue, tx_buf_addr, tx_buf_len, tx_cmd})
      `CHK("tx_eop", ev[0], tx_eop)
    end
    if (rx_wb_valid) begin
      ev = 57'(rx_q.pop_front());
      `CHK("rx_wb", ev, {rx_wb_queue, rx_wb_len})
    end
    if (tx_wb_valid) begin
      `CHK("tx_wb", {ord[wb_cnt], 2'(ws[ord[wb_cnt]])}, {tx_wb_queue, tx_wb_index})
      ws[ord[wb_cnt]]++;
      wb_cnt++;
    end
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(8'h2C, 32'hFFFFFFFF);
    wr(`NDQ_OFF_CAPS, 32'h0);
    rd(8'h2C, 32'h0);
    rd(`NDQ_OFF_CTRL, `NDQ_CTRL_RST);
    rd(`NDQ_OFF_CAPS, 32'h180);
    wr(`NDQ_OFF_PRIO, 32'h1);
    wr(`NDQ_OFF_TUNE0, 32'h2);
    rd(`NDQ_OFF_PRIO, 32'h1);
    rd(`NDQ_OFF_TUNE0, 32'h2);
    rd(`NDQ_OFF_TUNE1, 32'h1);
    drain(20);
    $display("test registers done");
    for (int i = 0; i < 5; i++) commit(1'b0, i[2:0]);
    for (int i = 5; i < 7; i++) commit(1'b1, i[2:0]);
    foreach (ord[k]) tx_q.push_back(ord[k] ? {1'b1, cq1.pop_front()} : {1'b0, cq0.pop_front()});
    rd(`NDQ_OFF_TXSTAT, 32'h2040);
    wr(`NDQ_OFF_CTRL, 32'h0D);
    drain(400);
    repeat (3) @(posedge clk);
    rd(`NDQ_OFF_TXSTAT, 32'h2244);
    `CHK("tx_wb_count", 6, wb_cnt)
    $display("test transmit done");
    for (int i = 0; i < 15; i++) wr(`NDQ_OFF_RXPOST, {31'h0, i > 7});
    cred = '{3'h7, 3'h7};
    pkt(1'b1);
    for (int m = 0; m < 3; m++) begin
      ctl = {1'b0, m[1:0], 4'h2};
      wr(`NDQ_OFF_CTRL, {25'h0, ctl});
      repeat (3) pkt(1'b1);
    end
    pkt(1'b0);
    drain(20);
    rd(`NDQ_OFF_RXSTAT, {14'h0, 2'b10, drops, 1'b0, cred[1], 1'b0, cred[0]});
    $display("test receive done");
    wr(`NDQ_OFF_CTRL, 32'h40);
    repeat (5) @(posedge clk);
    `CHK("tsync_active", 1'b1, tsync_active)
    fdx <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("tsync_active", 1'b0, tsync_active)
    $display("test time sync done");
    wr(`NDQ_OFF_TUNE0, 32'h5);
    wr(`NDQ_OFF_CTRL, 32'h80000000);
    repeat (3) @(posedge clk);
    rd(`NDQ_OFF_TUNE0, 32'h1);
    rd(`NDQ_OFF_PRIO, 32'h0);
    rd(`NDQ_OFF_CTRL, 32'h0);
    rd(`NDQ_OFF_TXSTAT, 32'h0);
    rd(`NDQ_OFF_RXSTAT, 32'h0);
    drain(20);
    $display("test function reset done");
    finish_test();
  end
endmodule
